// file: ssl_top.sv
// Module: serial station link, register slave and message framing
// How it works
// - Line rate code 0 gives 4800 bit/s and code 2 gives 19200 bit/s, and 0 is the reset value.
// - Format codes 0, 2 and 4 give 8N1 ASCII, 8E1 ASCII and 8O1 RTU.
// - A station number 1 to 240 is held and only matching messages are accepted.
// - Station number 0 disables the link: nothing is accepted or sent.
// - In ASCII each byte travels as two characters, high nibble first.
// - Hex digits map to 30h-39h and upper-case 41h-46h both ways.
// - No-parity ASCII characters take ten bit times, LSB first.
// - No-parity RTU characters also take ten bit times.
// - An ASCII message ends with CR then LF.
// - RTU messages are bounded by at least 10 ms of idle line.
// - Address 00h is broadcast and is accepted besides the own number.
// - The ASCII check is the two's complement of the 8-bit byte sum.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ssl_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        rxd,
  output var  logic        txd
);
  // ---------------------------------------------------------------
  // Hex digit helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] nib2asc(input logic [3:0] n);
    nib2asc = (n < ssl_pkg::NIB_TEN) ? ssl_pkg::ASC_ZERO + {4'h0, n}
                                     : ssl_pkg::ASC_A_LESS10 + {4'h0, n};
  endfunction
  function automatic logic [3:0] asc2nib(input logic [7:0] c);
    asc2nib = (c >= 8'h41) ? 4'(c - ssl_pkg::ASC_A_LESS10) : 4'(c - ssl_pkg::ASC_ZERO);
  endfunction

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  logic [1:0]  line_rate_select;
  logic [2:0]  frame_format_select;
  logic [7:0]  station_number;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  ap_addr;
  logic        link_en;
  logic        ascii_mode;
  logic [7:0]  status;
  logic        tx_req;
  logic [7:0]  tx_req_byte;
  logic        rx_valid;
  logic [7:0]  rx_data;
  ssl_char_if  ch ();

  assign link_en    = (station_number != ssl_pkg::STATION_RST);
  assign ascii_mode = (frame_format_select < 3'h3);

  // Address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      ap_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      rd_pend <= hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1]) ap_addr <= haddr[7:0];
    end
  end

  // Configuration registers; illegal codes are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_rate_select    <= ssl_pkg::RATE_RST;
      frame_format_select <= ssl_pkg::FMT_RST;
      station_number      <= ssl_pkg::STATION_RST;
    end else if (wr_pend) begin
      case (ap_addr)
        ssl_pkg::A_LINE_RATE: line_rate_select <= hwdata[1:0];
        ssl_pkg::A_FRAME_FMT:
          if (hwdata[2:0] <= ssl_pkg::FMT_MAX) frame_format_select <= hwdata[2:0];
        ssl_pkg::A_STATION:
          if (hwdata[7:0] <= ssl_pkg::STATION_MAX) station_number <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data mux, registered in the address phase cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        ssl_pkg::A_LINE_RATE: hrdata <= {30'h0, line_rate_select};
        ssl_pkg::A_FRAME_FMT: hrdata <= {29'h0, frame_format_select};
        ssl_pkg::A_STATION:   hrdata <= {24'h0, station_number};
        ssl_pkg::A_STATUS:    hrdata <= {24'h0, status};
        ssl_pkg::A_RX_DATA:   hrdata <= {24'h0, rx_data};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Transmit request from software, taken when the serialiser is free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_req      <= 1'b0;
      tx_req_byte <= 8'h00;
    end else if (wr_pend && ap_addr == ssl_pkg::A_TX_DATA && link_en) begin
      tx_req      <= 1'b1;
      tx_req_byte <= hwdata[7:0];
    end else if (tx_req && !ch.tx_busy && !ch.tx_go) begin
      tx_req <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Line rate and character format
  // ---------------------------------------------------------------
  always_comb begin
    case (line_rate_select)
      2'h0:    ch.bit_div = ssl_pkg::DIV_4800;
      2'h1:    ch.bit_div = ssl_pkg::DIV_9600;
      2'h2:    ch.bit_div = ssl_pkg::DIV_19200;
      default: ch.bit_div = ssl_pkg::DIV_38400;
    endcase
    case (frame_format_select)
      3'h1, 3'h4: ch.par = ssl_pkg::SSL_PAR_ODD;
      3'h2, 3'h5: ch.par = ssl_pkg::SSL_PAR_EVEN;
      default:    ch.par = ssl_pkg::SSL_PAR_NONE;
    endcase
  end

  // ---------------------------------------------------------------
  // Transmit: ASCII splits each byte into two hex characters
  // ---------------------------------------------------------------
  logic       tx_lo_pend;
  logic [3:0] tx_lo_nib;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch.tx_go    <= 1'b0;
      ch.tx_byte  <= 8'h00;
      tx_lo_pend  <= 1'b0;
      tx_lo_nib   <= 4'h0;
    end else begin
      ch.tx_go <= 1'b0;
      if (!ch.tx_busy && !ch.tx_go) begin
        if (tx_lo_pend) begin
          ch.tx_go   <= 1'b1;
          ch.tx_byte <= nib2asc(tx_lo_nib);
          tx_lo_pend <= 1'b0;
        end else if (tx_req) begin
          ch.tx_go <= 1'b1;
          if (ascii_mode) begin
            ch.tx_byte <= nib2asc(tx_req_byte[7:4]);
            tx_lo_nib  <= tx_req_byte[3:0];
            tx_lo_pend <= 1'b1;
          end else begin
            ch.tx_byte <= tx_req_byte;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive framing: address filter, pairing, check, end marks
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {SSL_WAIT, SSL_ADDR, SSL_BODY, SSL_LF, SSL_SKIP} ssl_rx_state_t;
  ssl_rx_state_t rx_state;
  logic       hi_half;
  logic [3:0] hi_nib;
  logic [7:0] lrc_sum;
  logic       addr_hit;
  logic       lrc_ok;
  logic       par_err;
  logic       frm_err;
  logic [7:0] rx_cbyte;
  logic       byte_ok;
  logic [7:0] asc_byte;
  always_comb begin
    asc_byte = {hi_nib, asc2nib(ch.rx_byte)};
    rx_cbyte = ascii_mode ? asc_byte : ch.rx_byte;
    byte_ok  = (rx_cbyte == station_number) || (rx_cbyte == ssl_pkg::BROADCAST);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= SSL_WAIT;
      hi_half  <= 1'b1;
      hi_nib   <= 4'h0;
      lrc_sum  <= 8'h00;
      addr_hit <= 1'b0;
      lrc_ok   <= 1'b0;
      par_err  <= 1'b0;
      frm_err  <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      // Reading data clears valid; a new byte in the same cycle wins
      if (rd_pend && ap_addr == ssl_pkg::A_RX_DATA) rx_valid <= 1'b0;
      if (rd_pend && ap_addr == ssl_pkg::A_STATUS) begin
        par_err <= 1'b0;
        frm_err <= 1'b0;
      end
      // Errors kept for every character, start marks too; set beats clear
      if (ch.rx_done && ch.rx_par_err) par_err <= 1'b1;
      if (ch.rx_done && ch.rx_frm_err) frm_err <= 1'b1;
      if (!link_en) begin
        rx_state <= SSL_WAIT;
        addr_hit <= 1'b0;
      end else if (ascii_mode && ch.rx_done && ch.rx_byte == ssl_pkg::ASC_START) begin
        rx_state <= SSL_ADDR;
        hi_half  <= 1'b1;
        lrc_sum  <= 8'h00;
        addr_hit <= 1'b0;
      end else if (!ascii_mode && ch.line_idle) begin
        rx_state <= SSL_ADDR;
        hi_half  <= 1'b1;
      end else if (ch.rx_done) begin
        case (rx_state)
          SSL_ADDR, SSL_BODY:
            if (ascii_mode && ch.rx_byte == ssl_pkg::ASC_CR) begin
              rx_state <= SSL_LF;
            end else if (ascii_mode && hi_half) begin
              hi_nib  <= asc2nib(ch.rx_byte);
              hi_half <= 1'b0;
            end else begin
              hi_half <= 1'b1;
              lrc_sum <= lrc_sum + rx_cbyte;
              if (rx_state == SSL_ADDR) begin
                addr_hit <= byte_ok;
                rx_state <= byte_ok ? SSL_BODY : SSL_SKIP;
              end
              if (rx_state == SSL_BODY || byte_ok) begin
                rx_data  <= rx_cbyte;
                rx_valid <= 1'b1;
              end
            end
          SSL_LF:
            if (ch.rx_byte == ssl_pkg::ASC_LF) begin
              lrc_ok   <= (lrc_sum == 8'h00);
              rx_state <= SSL_WAIT;
            end
          default: ;
        endcase
      end
    end
  end

  // Status word gathered from live state
  always_comb begin
    status                        = 8'h00;
    status[ssl_pkg::ST_TX_BUSY]   = ch.tx_busy | tx_req | tx_lo_pend;
    status[ssl_pkg::ST_RX_VALID]  = rx_valid;
    status[ssl_pkg::ST_ADDR_HIT]  = addr_hit;
    status[ssl_pkg::ST_PAR_ERR]   = par_err;
    status[ssl_pkg::ST_FRM_ERR]   = frm_err;
    status[ssl_pkg::ST_ENABLED]   = link_en;
    status[ssl_pkg::ST_LRC_OK]    = lrc_ok;
    status[ssl_pkg::ST_IDLE_GAP]  = ch.line_idle;
  end

  ssl_phy u_phy (
    .hclk    (hclk),
    .hresetn (hresetn),
    .rxd     (rxd),
    .txd     (txd),
    .ch      (ch.phy)
  );
endmodule // ssl_top
`default_nettype wire

// file: ssl_pkg.sv
// Package: constants and types for the serial station link
package ssl_pkg;
  // Clock and bit timing
  localparam int unsigned CLK_HZ        = 50000000;
  localparam logic [31:0] CLK_HZ_W      = 32'(CLK_HZ);
  localparam int unsigned IDLE_GAP_US   = 10000;
  localparam int unsigned IDLE_GAP_CYC  = (CLK_HZ / 1000000) * IDLE_GAP_US;
  localparam logic [15:0] DIV_4800      = 16'(CLK_HZ / 4800);
  localparam logic [15:0] DIV_9600      = 16'(CLK_HZ / 9600);
  localparam logic [15:0] DIV_19200     = 16'(CLK_HZ / 19200);
  localparam logic [15:0] DIV_38400     = 16'(CLK_HZ / 38400);
  // Register byte addresses
  localparam logic [7:0]  A_LINE_RATE   = 8'h00;
  localparam logic [7:0]  A_FRAME_FMT   = 8'h04;
  localparam logic [7:0]  A_STATION     = 8'h08;
  localparam logic [7:0]  A_STATUS      = 8'h0C;
  localparam logic [7:0]  A_TX_DATA     = 8'h10;
  localparam logic [7:0]  A_RX_DATA     = 8'h14;
  // Reset values, limits and character codes
  localparam logic [1:0]  RATE_RST      = 2'h0;
  localparam logic [2:0]  FMT_RST       = 3'h0;
  localparam logic [2:0]  FMT_MAX       = 3'h5;
  localparam logic [7:0]  STATION_RST   = 8'h00;
  localparam logic [7:0]  STATION_MAX   = 8'hF0;
  localparam logic [7:0]  BROADCAST     = 8'h00;
  localparam logic [7:0]  ASC_START     = 8'h3A;
  localparam logic [7:0]  ASC_CR        = 8'h0D;
  localparam logic [7:0]  ASC_LF        = 8'h0A;
  localparam logic [7:0]  ASC_ZERO      = 8'h30;
  localparam logic [7:0]  ASC_A_LESS10  = 8'h37;
  localparam logic [3:0]  NIB_TEN       = 4'hA;
  localparam logic [3:0]  DATA_BITS     = 4'h8;
  // Status bit positions
  localparam int unsigned ST_TX_BUSY    = 0;
  localparam int unsigned ST_RX_VALID   = 1;
  localparam int unsigned ST_ADDR_HIT   = 2;
  localparam int unsigned ST_PAR_ERR    = 3;
  localparam int unsigned ST_FRM_ERR    = 4;
  localparam int unsigned ST_ENABLED    = 5;
  localparam int unsigned ST_LRC_OK     = 6;
  localparam int unsigned ST_IDLE_GAP   = 7;
  // Parity kinds
  typedef enum logic [1:0] {SSL_PAR_NONE, SSL_PAR_ODD, SSL_PAR_EVEN} ssl_par_t;
endpackage

// file: ssl_char_if.sv
// Interface: character stream between link core and serialiser
`timescale 1ns/1ps
`default_nettype none
interface ssl_char_if;
  logic [15:0]       bit_div;
  ssl_pkg::ssl_par_t par;
  logic [7:0]        tx_byte;
  logic              tx_go;
  logic              tx_busy;
  logic [7:0]        rx_byte;
  logic              rx_done;
  logic              rx_par_err;
  logic              rx_frm_err;
  logic              line_idle;
  modport core (output bit_div, par, tx_byte, tx_go,
                input tx_busy, rx_byte, rx_done, rx_par_err, rx_frm_err, line_idle);
  modport phy  (input bit_div, par, tx_byte, tx_go,
                output tx_busy, rx_byte, rx_done, rx_par_err, rx_frm_err, line_idle);
endinterface
`default_nettype wire

// file: ssl_phy.sv
// Module: bit-level serialiser and deserialiser for one character
`timescale 1ns/1ps
`default_nettype none
module ssl_phy (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic rxd,
  output var  logic txd,
  ssl_char_if.phy   ch
);
  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  logic       rx_m;
  logic       rx_s;
  // Two stages; only rx_s is looked at by logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      rx_m <= rxd;
      rx_s <= rx_m;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  logic [10:0] tx_sh;
  logic [3:0]  tx_left;
  logic [15:0] tx_cnt;
  logic        tx_pbit;
  always_comb tx_pbit = (ch.par == ssl_pkg::SSL_PAR_ODD) ? ~^ch.tx_byte : ^ch.tx_byte;
  assign ch.tx_busy = (tx_left != 4'h0);
  // Start, eight data LSB first, optional parity, stop: 10 or 11 bit times
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh   <= 11'h7FF;
      tx_left <= 4'h0;
      tx_cnt  <= 16'h0000;
      txd     <= 1'b1;
    end else if (tx_left == 4'h0) begin
      txd <= 1'b1;
      if (ch.tx_go) begin
        tx_cnt <= 16'h0000;
        if (ch.par == ssl_pkg::SSL_PAR_NONE) begin
          tx_sh   <= {2'b11, ch.tx_byte, 1'b0};
          tx_left <= 4'hA;
        end else begin
          tx_sh   <= {1'b1, tx_pbit, ch.tx_byte, 1'b0};
          tx_left <= 4'hB;
        end
      end
    end else begin
      txd <= tx_sh[0];
      if (tx_cnt == ch.bit_div - 16'h0001) begin
        tx_cnt  <= 16'h0000;
        tx_sh   <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
      end else begin
        tx_cnt <= tx_cnt + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  logic [3:0]  rx_idx;
  logic        rx_on;
  logic [15:0] rx_cnt;
  logic [8:0]  rx_sh;
  logic [3:0]  rx_last;
  always_comb rx_last = (ch.par == ssl_pkg::SSL_PAR_NONE) ? 4'h9 : 4'hA;
  // Samples mid-bit; start bit is rechecked at its centre to reject glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_on      <= 1'b0;
      rx_idx     <= 4'h0;
      rx_cnt     <= 16'h0000;
      rx_sh      <= 9'h000;
      ch.rx_byte <= 8'h00;
      ch.rx_done <= 1'b0;
      ch.rx_par_err <= 1'b0;
      ch.rx_frm_err <= 1'b0;
    end else begin
      ch.rx_done <= 1'b0;
      if (!rx_on) begin
        if (!rx_s) begin
          rx_on  <= 1'b1;
          rx_idx <= 4'h0;
          rx_cnt <= {1'b0, ch.bit_div[15:1]};
        end
      end else if (rx_cnt == 16'h0000) begin
        rx_cnt <= ch.bit_div - 16'h0001;
        if (rx_idx == 4'h0 && rx_s) begin
          rx_on <= 1'b0;
        end else if (rx_idx == rx_last) begin
          rx_on         <= 1'b0;
          ch.rx_done    <= 1'b1;
          ch.rx_byte    <= rx_sh[7:0];
          ch.rx_frm_err <= ~rx_s;
          case (ch.par)
            ssl_pkg::SSL_PAR_ODD:  ch.rx_par_err <= ~(^rx_sh);
            ssl_pkg::SSL_PAR_EVEN: ch.rx_par_err <= ^rx_sh;
            default:               ch.rx_par_err <= 1'b0;
          endcase
        end else begin
          rx_idx <= rx_idx + 4'h1;
          if (rx_idx != 4'h0) begin
            if (rx_idx <= ssl_pkg::DATA_BITS) rx_sh <= {rx_sh[8], rx_s, rx_sh[7:1]};
            else rx_sh[8] <= rx_s;
          end
        end
      end else begin
        rx_cnt <= rx_cnt - 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Idle line timer
  // ---------------------------------------------------------------
  logic [31:0] idle_cnt;
  // Counts cycles of marking line, saturates at the gap length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt     <= 32'h0000_0000;
      ch.line_idle <= 1'b0;
    end else if (!rx_s || rx_on) begin
      idle_cnt     <= 32'h0000_0000;
      ch.line_idle <= 1'b0;
    end else if (idle_cnt < 32'(ssl_pkg::IDLE_GAP_CYC)) begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end else begin
      ch.line_idle <= 1'b1;
    end
  end
endmodule // ssl_phy
`default_nettype wire

// file: ssl_monitor.sv
// Checker: port-level assertions for the serial station link
`timescale 1ns/1ps
`default_nettype none
module ssl_monitor (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        txd
);
  logic        ap_v;
  logic        ap_w;
  logic [7:0]  ap_a;
  logic        rd_cyc;
  logic [1:0]  rate_sh;
  logic [2:0]  fmt_sh;
  logic [7:0]  stn_sh;
  logic        prev_txd;
  logic [31:0] run;
  logic [31:0] div;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Address phase capture, so the data phase knows what it serves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_v <= 1'b0;
      ap_w <= 1'b0;
      ap_a <= 8'h00;
    end else begin
      ap_v <= hsel & hready & htrans[1];
      ap_w <= hwrite;
      ap_a <= haddr[7:0];
    end
  end
  assign rd_cyc = ap_v & ~ap_w;

  // Shadow settings; out-of-range writes are dropped like the slave does
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_sh <= ssl_pkg::RATE_RST;
      fmt_sh  <= ssl_pkg::FMT_RST;
      stn_sh  <= ssl_pkg::STATION_RST;
    end else if (ap_v && ap_w) begin
      if (ap_a == ssl_pkg::A_LINE_RATE) rate_sh <= hwdata[1:0];
      if (ap_a == ssl_pkg::A_FRAME_FMT && hwdata[2:0] <= ssl_pkg::FMT_MAX) fmt_sh <= hwdata[2:0];
      if (ap_a == ssl_pkg::A_STATION && hwdata[7:0] <= ssl_pkg::STATION_MAX) stn_sh <= hwdata[7:0];
    end
  end

  // Length of the current txd level; saturates so a long idle stays long
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_txd <= 1'b1;
      run      <= 32'hFFFF_FFFF;
    end else begin
      prev_txd <= txd;
      if (txd != prev_txd) run <= 32'h1;
      else if (run != 32'hFFFF_FFFF) run <= run + 32'h1;
    end
  end

  // Bit period for the selected rate
  assign div = {16'h0, rate_sh == 2'h0 ? ssl_pkg::DIV_4800 :
                       rate_sh == 2'h1 ? ssl_pkg::DIV_9600 :
                       rate_sh == 2'h2 ? ssl_pkg::DIV_19200 : ssl_pkg::DIV_38400};

  AST_RATE_READ: assert property (rd_cyc && ap_a == ssl_pkg::A_LINE_RATE |-> hrdata == {30'h0, rate_sh})
    else $error("line rate readback wrong");
  AST_FMT_READ: assert property (rd_cyc && ap_a == ssl_pkg::A_FRAME_FMT |-> hrdata == {29'h0, fmt_sh})
    else $error("frame format readback wrong");
  AST_STATION_READ: assert property (rd_cyc && ap_a == ssl_pkg::A_STATION |-> hrdata == {24'h0, stn_sh})
    else $error("station readback wrong");
  AST_ENABLED_FLAG: assert property (rd_cyc && ap_a == ssl_pkg::A_STATUS |-> hrdata[5] == (stn_sh != 8'h00))
    else $error("enabled flag wrong");
  AST_SILENT_OFF: assert property (stn_sh == 8'h00 && txd && run > div * 32'hC |=> txd)
    else $error("txd active while link disabled");
  AST_BIT_MIN: assert property (txd != prev_txd |-> run >= div)
    else $error("txd level shorter than one bit");
  AST_LOW_MAX: assert property (txd && !prev_txd |-> run <= div * 32'hA)
    else $error("txd low longer than a character");
  AST_IDLE_HIGH: assert property ($rose(hresetn) |-> txd)
    else $error("txd not idle after reset");

  COV_TX_WRITE: cover property (ap_v && ap_w && ap_a == ssl_pkg::A_TX_DATA);
  COV_START_BIT: cover property ($fell(txd));
  COV_FRAME_ERR: cover property (rd_cyc && ap_a == ssl_pkg::A_STATUS && hrdata[4]);
endmodule // ssl_monitor

bind ssl_top ssl_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .txd(txd)
);
`default_nettype wire

// file: ssl_host_model.sv
// Host model: serial bus master on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module ssl_host_model (
  input  wire logic        hclk,
  input  wire logic        txd,
  input  wire logic [15:0] bit_div,
  output var  logic        rxd
);
  logic [8:0] got_q[$];
  logic [8:0] sh;

  // Line rests high between characters, as the bus bias leaves it
  initial rxd = 1'b1;

  // Send a pre-framed character LSB first, then release the line
  task automatic send_bits(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bit_div) @(posedge hclk);
    end
    rxd <= 1'b1;
    // Let an edge pass so a following call never drives rxd twice in a step
    @(posedge hclk);
  endtask

  // Centre-sample eight data bits and the next bit (stop, or parity when parity is used) of each character
  always begin
    @(posedge hclk);
    if (txd === 1'b0) begin
      repeat (bit_div / 2) @(posedge hclk);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_div) @(posedge hclk);
        sh[i] = txd;
      end
      got_q.push_back(sh);
      while (txd !== 1'b1) @(posedge hclk);
    end
  end
endmodule // ssl_host_model
`default_nettype wire

// file: test_serial_station_link_setup.sv
// Testbench: register and serial character checks for the station link
`timescale 1ns/1ps
`default_nettype none
module test_serial_station_link_setup;
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } ssl_row_t;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rxd;
  logic        txd;
  int          n_mismatch = 0;
  int          n_tests = 0;
  logic [31:0] rd;
  int          k;

  // Address, write, data, read mask, expected read
  ssl_row_t rows [13] = '{
    '{8'h00, 1'b1, 32'h2, 32'h3, 32'h2},
    '{8'h00, 1'b1, 32'h1, 32'h3, 32'h1},
    '{8'h00, 1'b1, 32'h0, 32'h3, 32'h0},
    '{8'h00, 1'b1, 32'h3, 32'h3, 32'h3},
    '{8'h04, 1'b1, 32'h5, 32'h7, 32'h5},
    '{8'h04, 1'b1, 32'h6, 32'h7, 32'h5},
    '{8'h04, 1'b1, 32'h4, 32'h7, 32'h4},
    '{8'h08, 1'b1, 32'hF0, 32'hFF, 32'hF0},
    '{8'h08, 1'b1, 32'hF1, 32'hFF, 32'hF0},
    '{8'h0C, 1'b0, 32'h0, 32'h20, 32'h20},
    '{8'h08, 1'b1, 32'h0, 32'hFF, 32'h0},
    '{8'h0C, 1'b0, 32'h0, 32'h20, 32'h0},
    '{8'h18, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h0}
  };

  assign hready = hreadyout;

  ssl_top uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd)
  );
  ssl_host_model u_host (.hclk(hclk), .txd(txd), .bit_div(ssl_pkg::DIV_38400), .rxd(rxd));

  // 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic print_verdict;
    $display("counts: %0d mismatches in %0d tests", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bounded wait for hready; a stuck slave ends the run
  task automatic wait_rdy;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_mismatch++;
        print_verdict;
      end
      @(posedge hclk);
    end
  endtask

  // One single AHB-Lite transfer; hsel stays up so no pin toggles twice per step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 13; i++) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d, rd);
      bus(1'b0, rows[i].a, 32'h0, rd);
      check("register row", rd & rows[i].m, rows[i].e);
    end
    // Disabled link must swallow a transmit request
    bus(1'b1, 8'h10, 32'h4B, rd);
    repeat (300) @(posedge hclk);
    bus(1'b0, 8'h0C, 32'h0, rd);
    check("busy while off", rd & 32'h1, 32'h0);
    check("chars while off", 32'(u_host.got_q.size()), 32'h0);
    // ASCII byte with a letter nibble, at the fastest rate
    bus(1'b1, 8'h04, 32'h0, rd);
    bus(1'b1, 8'h08, 32'h5, rd);
    bus(1'b1, 8'h10, 32'h4B, rd);
    bus(1'b0, 8'h0C, 32'h0, rd);
    check("busy", rd & 32'h1, 32'h1);
    for (k = 0; k < 40000 && u_host.got_q.size() < 2; k++) @(posedge hclk);
    check("char count", 32'(u_host.got_q.size()), 32'h2);
    if (u_host.got_q.size() < 2) print_verdict;
    check("high nibble char", {23'h0, u_host.got_q[0]}, 32'h134);
    check("low nibble char", {23'h0, u_host.got_q[1]}, 32'h142);
    // Stop bit held low, then a wrong even parity bit
    u_host.send_bits(11'h074, 10);
    repeat (20) @(posedge hclk);
    bus(1'b0, 8'h0C, 32'h0, rd);
    check("stop bit low", rd & 32'h18, 32'h10);
    bus(1'b0, 8'h0C, 32'h0, rd);
    check("error cleared", rd & 32'h18, 32'h0);
    // Start of an ASCII message addressed to station 5
    u_host.send_bits({2'b11, 8'h3A, 1'b0}, 10);
    u_host.send_bits({2'b11, 8'h30, 1'b0}, 10);
    u_host.send_bits({2'b11, 8'h35, 1'b0}, 10);
    repeat (20) @(posedge hclk);
    bus(1'b0, 8'h0C, 32'h0, rd);
    check("address hit", rd & 32'h6, 32'h6);
    bus(1'b0, 8'h14, 32'h0, rd);
    check("rx byte", rd, 32'h5);
    bus(1'b1, 8'h04, 32'h2, rd);
    u_host.send_bits(11'h674, 11);
    repeat (20) @(posedge hclk);
    bus(1'b0, 8'h0C, 32'h0, rd);
    check("parity wrong", rd & 32'h18, 32'h08);
    // Second reset in mid-run restores the defaults
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check("txd in reset", {31'h0, txd}, 32'h1);
    check("hrdata in reset", hrdata, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0, rd);
      check("reset value", rd, 32'h0);
    end
    print_verdict;
  end
endmodule // test_serial_station_link_setup
`default_nettype wire
